//--- mris_adder.v
// Twelve-bit adder of the shared register gating network
`timescale 1ns/100ps
`default_nettype none
module mris_adder (
	// Operands, bit 0 is the most significant
	input  wire [0:11] add_a,
	input  wire [0:11] add_b,
	input  wire        carry_in,
	// Result
	output wire [0:11] sum,
	output wire        carry_out
);

	// Carry ripples from bit 11 up to bit 0
	assign {carry_out, sum} = {1'b0, add_a} + {1'b0, add_b} + {12'h000, carry_in};

endmodule
`default_nettype wire

//--- mris_core_model.sv
// Behavioural core memory answering read and rewrite cycles
`timescale 1ns/100ps
`default_nettype none
module mris_core_model (
	// Clock, reset and memory speed select
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        slow,
	// Memory link
	input  wire logic        mem_read,
	input  wire logic [0:11] mem_addr,
	output var  logic        mem_strobe,
	output var  logic [0:11] mem_sense_data,
	input  wire logic        mem_rewrite,
	input  wire logic [0:11] mem_write_data,
	output var  logic        mem_done
);
	logic [0:11] core [0:4095];
	logic [0:11] ra;
	logic [0:11] wa;
	logic [2:0]  rc;
	logic [2:0]  wc;
	initial for (int i = 0; i < 4096; i++) core[i] = 12'he00;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{mem_strobe, mem_done, rc, wc} <= '0;
			mem_sense_data <= 12'h000;
		end else begin
			mem_strobe <= 1'b0;
			mem_done <= 1'b0;
			// Sense lines are not valid outside the strobe
			mem_sense_data <= ~mem_sense_data;
			if (mem_read) begin
				ra <= mem_addr;
				rc <= slow ? 3'h4 : 3'h1;
			end else if (rc != 3'h0) begin
				rc <= rc - 3'h1;
				if (rc == 3'h1) begin
					mem_strobe <= 1'b1;
					mem_sense_data <= core[ra];
				end
			end
			if (mem_rewrite) begin
				wa <= mem_addr;
				wc <= slow ? 3'h5 : 3'h1;
			end else if (wc != 3'h0) begin
				wc <= wc - 3'h1;
				if (wc == 3'h1) begin
					mem_done <= 1'b1;
					core[wa] <= mem_write_data;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- mris_defs.vh
// Constants for the memory reference instruction sequencer
`ifndef MRIS_DEFS_VH
`define MRIS_DEFS_VH

// Data path
`define MRIS_W           12
`define MRIS_OP_AND      3'h0
`define MRIS_OP_TAD      3'h1
`define MRIS_OP_ISZ      3'h2

// Major states
`define MRIS_MAJ_FETCH   2'h0
`define MRIS_MAJ_DEFER   2'h1
`define MRIS_MAJ_EXEC    2'h2
`define MRIS_MAJ_BREAK   2'h3

// Time states
`define MRIS_TS1         2'h0
`define MRIS_TS2         2'h1
`define MRIS_TS3         2'h2
`define MRIS_TS4         2'h3

// Timing
`define MRIS_CLK_MHZ     50
`define MRIS_TS_MIN_NS   40
`define MRIS_TS_CYCLES   ((`MRIS_TS_MIN_NS * `MRIS_CLK_MHZ + 999) / 1000)

// Register port offsets
`define MRIS_REG_ACC     3'h0
`define MRIS_REG_PC      3'h1
`define MRIS_REG_MA      3'h2
`define MRIS_REG_MB      3'h3
`define MRIS_REG_STATUS  3'h4
`define MRIS_REG_CTRL    3'h5
`define MRIS_REG_COUNT   3'h6

// Control register fields and reset values
`define MRIS_CTRL_RUN    11
`define MRIS_CTRL_RESET  12'h000
`define MRIS_WORD_RESET  12'h000

`endif

//--- mris_seq.v
// Memory reference instruction sequencer: major states and datapath
`timescale 1ns/100ps
`default_nettype none
`include "mris_defs.vh"
module mris_seq (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// Register port
	input  wire [2:0]  reg_addr,
	input  wire [0:11] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [0:11] reg_rdata,
	// Core memory
	output wire        mem_read,
	output wire [0:11] mem_addr,
	input  wire        mem_strobe,
	input  wire [0:11] mem_sense_data,
	output wire        mem_rewrite,
	output wire [0:11] mem_write_data,
	input  wire        mem_done,
	// Break logic
	input  wire        break_req,
	output reg         break_grant,
	input  wire        break_done,
	// Major state levels
	output wire        fetch_state,
	output wire        defer_state,
	output wire        execute_state
);

	reg  [0:11] accumulator;
	reg  [0:11] program_counter;
	reg  [0:11] mem_address_reg;
	reg  [0:11] mem_buffer_reg;
	reg  [0:11] sense_reg;
	reg  [0:2]  instr_reg;
	reg  [0:2]  exec_opcode;
	reg         skip_flag;
	reg  [1:0]  major;
	reg         run_ctl;
	reg  [0:11] instr_count;
	reg         timing_busy;

	wire [1:0]  time_state;
	wire        time_pulse_one;
	wire        time_pulse_two;
	wire        time_pulse_three;
	wire        time_pulse_four;
	wire        time_state_one;
	wire        time_state_two;
	wire        time_state_three;
	wire        time_state_four;
	wire        seq_run;
	wire        and_op;
	wire        twos_add_op;
	wire        incr_skip_zero_op;
	wire        page_select_bit;
	wire        indirect_bit;
	wire        in_fetch;
	wire        in_defer;
	wire        in_exec;
	wire        sw_access;
	wire [0:11] add_sum;
	wire        add_cout;
	wire [0:11] status_word;

	reg  [0:11] add_a;
	reg  [0:11] add_b;
	reg         add_cin;
	reg  [0:11] reg_bus;
	reg  [0:11] next_rdata;

	assign time_state_one = (time_state == `MRIS_TS1);
	assign time_state_two = (time_state == `MRIS_TS2);
	assign time_state_three = (time_state == `MRIS_TS3);
	assign time_state_four = (time_state == `MRIS_TS4);

	assign in_fetch = (major == `MRIS_MAJ_FETCH);
	assign in_defer = (major == `MRIS_MAJ_DEFER);
	assign in_exec = (major == `MRIS_MAJ_EXEC);
	// One code per major state, so two can never be active together
	assign fetch_state = in_fetch;
	assign defer_state = in_defer;
	assign execute_state = in_exec;

	// Latched at fetch so that the add reloading the opcode field keeps decoding
	assign and_op = (exec_opcode == `MRIS_OP_AND);
	assign twos_add_op = (exec_opcode == `MRIS_OP_TAD);
	assign incr_skip_zero_op = (exec_opcode == `MRIS_OP_ISZ);

	assign indirect_bit = mem_buffer_reg[3];
	assign page_select_bit = mem_buffer_reg[4];

	// Buffer always goes back to core, altered only by increment-skip
	assign mem_addr = mem_address_reg;
	assign mem_write_data = mem_buffer_reg;

	// Software may touch the datapath only while the processor is stopped
	// Writes during a cycle would race the load pulses of the running sequence
	assign sw_access = !run_ctl && !timing_busy;

	// Stop restarting memory at an instruction end that goes to break
	assign seq_run = run_ctl && (major != `MRIS_MAJ_BREAK) &&
		!(in_exec && break_req);

	assign status_word = {major, time_state, instr_reg, skip_flag,
		timing_busy, run_ctl, 2'h0};

	mris_timing u_timing (
		.clk              (clk),
		.rst_b            (rst_b),
		.run              (seq_run),
		.mem_strobe       (mem_strobe),
		.mem_done         (mem_done),
		.mem_read         (mem_read),
		.mem_rewrite      (mem_rewrite),
		.time_state       (time_state),
		.time_pulse_one   (time_pulse_one),
		.time_pulse_two   (time_pulse_two),
		.time_pulse_three (time_pulse_three),
		.time_pulse_four  (time_pulse_four)
	);

	mris_adder u_adder (
		.add_a     (add_a),
		.add_b     (add_b),
		.carry_in  (add_cin),
		.sum       (add_sum),
		.carry_out (add_cout)
	);

	// Source enables into the shared twelve-bit gating network
	// Only one source pair is enabled at a time; all others feed zeros
	always @* begin
		add_a = 12'h000;
		add_b = 12'h000;
		add_cin = 1'b0;
		if (in_fetch && time_state_one) begin
			add_a = mem_address_reg;
			add_cin = 1'b1;
		end else if (in_exec && time_state_two && incr_skip_zero_op) begin
			add_a = sense_reg;
			add_cin = 1'b1;
		end else if (in_exec && time_state_three && twos_add_op) begin
			add_a = accumulator;
			add_b = mem_buffer_reg;
		end else if (in_exec && time_state_three && incr_skip_zero_op) begin
			add_a = program_counter;
			add_cin = skip_flag;
		end
	end

	// AND takes the buffer below the adders, so no carry can reach it
	always @* begin
		if (in_exec && time_state_three && and_op)
			reg_bus = accumulator & mem_buffer_reg;
		else
			reg_bus = add_sum;
	end

	// Tracks whether a memory cycle is in flight
	// Cleared only at a final pulse four, so a stop never cuts a rewrite short
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			timing_busy <= 1'b0;
		else if (mem_read)
			timing_busy <= 1'b1;
		else if (time_pulse_four && !seq_run)
			timing_busy <= 1'b0;
	end

	// Sense register catches the word on the memory strobe
	// Sense lines are only valid while the strobe stands
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			sense_reg <= `MRIS_WORD_RESET;
		else if (mem_strobe)
			sense_reg <= mem_sense_data;
	end

	// Major state, skip flag and load pulses
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			accumulator <= `MRIS_WORD_RESET;
			program_counter <= `MRIS_WORD_RESET;
			mem_address_reg <= `MRIS_WORD_RESET;
			mem_buffer_reg <= `MRIS_WORD_RESET;
			instr_reg <= 3'h0;
			exec_opcode <= 3'h0;
			skip_flag <= 1'b0;
			major <= `MRIS_MAJ_FETCH;
			break_grant <= 1'b0;
			instr_count <= `MRIS_WORD_RESET;
		end else begin
			break_grant <= 1'b0;
			if (sw_access && reg_wr) begin
				case (reg_addr)
					`MRIS_REG_ACC: accumulator <= reg_wdata;
					`MRIS_REG_PC: program_counter <= reg_wdata;
					`MRIS_REG_MA: mem_address_reg <= reg_wdata;
					`MRIS_REG_COUNT: instr_count <= reg_wdata;
					default: ;
				endcase
			end
			if (time_pulse_one && in_fetch) begin
				program_counter <= reg_bus;
				// Stale skip from a stopped run must not reach the next execute
				skip_flag <= 1'b0;
			end
			if (time_pulse_two) begin
				case (major)
					`MRIS_MAJ_FETCH: begin
						instr_reg <= sense_reg[0:2];
						exec_opcode <= sense_reg[0:2];
						mem_buffer_reg <= sense_reg;
					end
					`MRIS_MAJ_DEFER: begin
						mem_buffer_reg <= sense_reg;
					end
					`MRIS_MAJ_EXEC: begin
						if (incr_skip_zero_op) begin
							mem_buffer_reg <= reg_bus;
							skip_flag <= add_cout;
						end else if (twos_add_op) begin
							mem_buffer_reg <= sense_reg;
							instr_reg <= sense_reg[0:2];
						end else begin
							mem_buffer_reg <= sense_reg;
						end
					end
					default: ;
				endcase
			end
			// Fetch third state has no load here for any decoded opcode
			if (time_pulse_three && in_exec) begin
				if (and_op || twos_add_op)
					accumulator <= reg_bus;
				// Address must hold until the rewrite lands in the same cell,
				// so only the counter moves now and reaches the address at pulse four, or at break end when a break is granted
				if (incr_skip_zero_op && skip_flag)
					program_counter <= reg_bus;
			end
			if (time_pulse_four) begin
				case (major)
					`MRIS_MAJ_FETCH: begin
						mem_address_reg[5:11] <= sense_reg[5:11];
						if (page_select_bit)
							mem_address_reg[0:4] <= sense_reg[0:4];
						else
							mem_address_reg[0:4] <= 5'h00;
						if (indirect_bit)
							major <= `MRIS_MAJ_DEFER;
						else
							major <= `MRIS_MAJ_EXEC;
					end
					`MRIS_MAJ_DEFER: begin
						// Pointer word read in this cycle becomes the operand address
						mem_address_reg <= mem_buffer_reg;
						major <= `MRIS_MAJ_EXEC;
					end
					`MRIS_MAJ_EXEC: begin
						instr_reg <= 3'h0;
						skip_flag <= 1'b0;
						instr_count <= instr_count + 12'h001;
						// Skip is only set by increment-skip, whose counter is already bumped
						if (!break_req && (!skip_flag || incr_skip_zero_op))
							mem_address_reg <= program_counter;
						if (break_req) begin
							major <= `MRIS_MAJ_BREAK;
							break_grant <= 1'b1;
						end else begin
							major <= `MRIS_MAJ_FETCH;
						end
					end
					default: ;
				endcase
			end
			// Break logic outside returns the machine to fetch
			// Address register may still point at the last operand
			if (major == `MRIS_MAJ_BREAK && break_done) begin
				major <= `MRIS_MAJ_FETCH;
				mem_address_reg <= program_counter;
			end
		end
	end

	// Control register
	// Run bit stays writable while running so software can stop the machine
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			run_ctl <= 1'b0;
		else if (reg_wr && reg_addr == `MRIS_REG_CTRL)
			run_ctl <= reg_wdata[`MRIS_CTRL_RUN];
	end

	// Read data stand only in the cycle after reg_rd
	// Zero elsewhere so a stale word is never mistaken for an answer
	always @* begin
		case (reg_addr)
			`MRIS_REG_ACC: next_rdata = accumulator;
			`MRIS_REG_PC: next_rdata = program_counter;
			`MRIS_REG_MA: next_rdata = mem_address_reg;
			`MRIS_REG_MB: next_rdata = mem_buffer_reg;
			`MRIS_REG_STATUS: next_rdata = status_word;
			`MRIS_REG_CTRL: next_rdata = {11'h000, run_ctl};
			`MRIS_REG_COUNT: next_rdata = instr_count;
			default: next_rdata = 12'h000;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 12'h000;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 12'h000;
	end

endmodule
`default_nettype wire

//--- mris_seq_sva.sv
// Assertions on the sequencer's memory link, major states and register port
`timescale 1ns/100ps
`default_nettype none
module mris_seq_chk (
	// Clock and reset
	input wire        clk,
	input wire        rst_b,
	// Observed ports
	input wire        reg_rd,
	input wire [0:11] reg_rdata,
	input wire        mem_read,
	input wire [0:11] mem_addr,
	input wire        mem_strobe,
	input wire        mem_rewrite,
	input wire [0:11] mem_write_data,
	input wire        mem_done,
	input wire        break_req,
	input wire        break_grant,
	input wire        fetch_state,
	input wire        defer_state,
	input wire        execute_state
);
	logic        in_write;
	logic [0:11] read_addr;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			read_addr <= 12'h000;
		else if (mem_read)
			read_addr <= mem_addr;
	end
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			in_write <= 1'b0;
		else if (mem_done)
			in_write <= 1'b0;
		else if (mem_rewrite)
			in_write <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_mid_states;
		!mem_rewrite [*4];
	endsequence
	sequence s_last_pulse;
		execute_state && mem_done;
	endsequence
	state_onehot_a: assert property ($onehot0({fetch_state, defer_state, execute_state}))
		else $error("more than one major state");
	exec_to_fetch_a: assert property (s_last_pulse ##0 !break_req |=>
		fetch_state && !break_grant)
		else $error("no fetch after instruction end");
	break_entry_a: assert property (s_last_pulse ##0 break_req |=>
		break_grant && !fetch_state && !execute_state)
		else $error("break not granted");
	state_choice_a: assert property (fetch_state && mem_done |=>
		defer_state == $past(mem_write_data[3]) && execute_state == !$past(mem_write_data[3]))
		else $error("wrong major state after fetch");
	addr_form_a: assert property (fetch_state && mem_done |=>
		mem_addr[5:11] == $past(mem_write_data[5:11]) &&
		mem_addr[0:4] == ($past(mem_write_data[4]) ? $past(mem_write_data[0:4]) : 5'h00))
		else $error("operand address formed wrongly");
	no_read_write_a: assert property (in_write |-> !mem_read)
		else $error("read started before memory done");
	wdata_hold_a: assert property (in_write |-> $stable(mem_write_data))
		else $error("write data moved during rewrite");
	same_cell_a: assert property (mem_rewrite |-> mem_addr == read_addr)
		else $error("rewrite address differs from read address");
	strobe_rewrite_a: assert property (mem_strobe |=> s_mid_states ##1 mem_rewrite)
		else $error("rewrite not after two time states");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 12'h000)
		else $error("read data outside answer cycle");
endmodule
bind mris_seq mris_seq_chk u_chk (.clk, .rst_b, .reg_rd, .reg_rdata, .mem_read, .mem_addr,
	.mem_strobe, .mem_rewrite, .mem_write_data, .mem_done, .break_req, .break_grant,
	.fetch_state, .defer_state, .execute_state);
`default_nettype wire

//--- mris_timing.v
// Time state and time pulse generator paced by the core memory
`timescale 1ns/100ps
`default_nettype none
`include "mris_defs.vh"
module mris_timing (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_b,
	// Control
	input  wire       run,
	// Core memory handshake
	input  wire       mem_strobe,
	input  wire       mem_done,
	output reg        mem_read,
	output reg        mem_rewrite,
	// Time states and pulses
	output reg  [1:0] time_state,
	output wire       time_pulse_one,
	output wire       time_pulse_two,
	output wire       time_pulse_three,
	output wire       time_pulse_four
);

	localparam integer TS_CYC = `MRIS_TS_CYCLES;
	localparam [2:0] TS_LAST = TS_CYC[2:0] - 3'h1;

	reg       active;
	reg [2:0] cnt;
	reg       strobe_seen;
	wire      cnt_done;

	assign cnt_done = (cnt == TS_LAST);
	assign time_pulse_one = active && time_state == `MRIS_TS1 && cnt_done &&
		(strobe_seen || mem_strobe);
	assign time_pulse_two = active && time_state == `MRIS_TS2 && cnt_done;
	assign time_pulse_three = active && time_state == `MRIS_TS3 && cnt_done;
	// Memory done ends the cycle, never the counter
	assign time_pulse_four = active && time_state == `MRIS_TS4 && mem_done;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			active <= 1'b0;
			cnt <= 3'h0;
			strobe_seen <= 1'b0;
			mem_read <= 1'b0;
			mem_rewrite <= 1'b0;
			time_state <= `MRIS_TS1;
		end else begin
			mem_read <= 1'b0;
			mem_rewrite <= 1'b0;
			if (!active) begin
				if (run) begin
					active <= 1'b1;
					time_state <= `MRIS_TS1;
					cnt <= 3'h0;
					mem_read <= 1'b1;
				end
			end else begin
				if (!cnt_done)
					cnt <= cnt + 3'h1;
				if (mem_strobe)
					strobe_seen <= 1'b1;
				if (time_pulse_one) begin
					strobe_seen <= 1'b0;
					cnt <= 3'h0;
					time_state <= `MRIS_TS2;
				end
				if (time_pulse_two) begin
					cnt <= 3'h0;
					time_state <= `MRIS_TS3;
				end
				if (time_pulse_three) begin
					mem_rewrite <= 1'b1;
					time_state <= `MRIS_TS4;
				end
				if (time_pulse_four) begin
					cnt <= 3'h0;
					time_state <= `MRIS_TS1;
					if (run)
						mem_read <= 1'b1;
					else
						active <= 1'b0;
				end
			end
		end
	end

endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench running a short program through the sequencer
`timescale 1ns/100ps
`default_nettype none
`include "mris_defs.vh"
module tb_top;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [2:0]  reg_addr = 3'h0;
	logic [0:11] reg_wdata = 12'h000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        break_req = 1'b0;
	logic        break_done = 1'b0;
	logic        slow = 1'b0;
	wire  [0:11] reg_rdata, mem_addr, mem_sense_data, mem_write_data;
	wire         mem_read, mem_strobe, mem_rewrite, mem_done;
	wire         break_grant, fetch_state, defer_state, execute_state;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          n_exec = 0;
	logic [0:11] fetch_q [$];
	logic [0:11] exp_f [7] = '{12'h000, 12'h001, 12'h002, 12'h004, 12'h005, 12'h006, 12'h007};
	// Program: AND, add, three increment-skips (one skipped), indirect AND, current-page add
	logic [0:11] pa [15] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
		12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h015, 12'h016, 12'h297};
	logic [0:11] pd [15] = '{12'h010, 12'h211, 12'h412, 12'h413, 12'h414, 12'h115, 12'h297,
		12'h0f3, 12'h005, 12'hfff, 12'h000, 12'h007, 12'h016, 12'h0f0, 12'h123};
	always #10 clk = ~clk;
	mris_seq u_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.mem_read, .mem_addr, .mem_strobe, .mem_sense_data, .mem_rewrite, .mem_write_data,
		.mem_done, .break_req, .break_grant, .break_done, .fetch_state, .defer_state,
		.execute_state);
	mris_core_model u_mem (.clk, .rst_b, .slow, .mem_read, .mem_addr, .mem_strobe,
		.mem_sense_data, .mem_rewrite, .mem_write_data, .mem_done);
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [0:11] seen, input logic [0:11] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [0:11] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [0:11] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task automatic wait_exec(input int n);
		for (int i = 0; i < 2000 && n_exec < n; i++)
			@(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (mem_read && fetch_state)
			fetch_q.push_back(mem_addr);
		if (execute_state && mem_done)
			n_exec <= n_exec + 1;
		if (cycles == 5000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rd(`MRIS_REG_ACC, `MRIS_WORD_RESET);
		rd(`MRIS_REG_STATUS, 12'h000);
		rd(3'h7, 12'h000);
		wr(`MRIS_REG_MB, 12'h555);
		rd(`MRIS_REG_MB, `MRIS_WORD_RESET);
		$display("Register test done");
		foreach (pa[i])
			u_mem.core[pa[i]] = pd[i];
		wr(`MRIS_REG_ACC, 12'hff0);
		wr(`MRIS_REG_MA, 12'h000);
		wr(`MRIS_REG_CTRL, 12'h001);
		wait_exec(3);
		// Slow memory for the second half of the program
		slow <= 1'b1;
		wait_exec(6);
		break_req <= 1'b1;
		for (int i = 0; i < 500 && break_grant !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk({9'h000, fetch_state, defer_state, execute_state}, 12'h000);
		@(posedge clk);
		break_req <= 1'b0;
		wr(`MRIS_REG_CTRL, 12'h000);
		@(posedge clk);
		break_done <= 1'b1;
		@(posedge clk);
		break_done <= 1'b0;
		#1;
		chk({11'h000, fetch_state}, 12'h001);
		$display("Break test done");
		rd(`MRIS_REG_ACC, 12'h213);
		chk(u_mem.core[12'h010], 12'h0f3);
		chk(u_mem.core[12'h011], 12'h005);
		chk(u_mem.core[12'h012], 12'h000);
		chk(u_mem.core[12'h013], 12'h000);
		chk(u_mem.core[12'h014], 12'h008);
		chk(u_mem.core[12'h004], 12'h414);
		foreach (exp_f[i])
			chk(fetch_q[i], exp_f[i]);
		$display("Program test done");
		complete_run;
	end
endmodule
`default_nettype wire
